// ### shared/ldb_defines.vh
// register offsets, field positions and reset values for the display dma sizing block
// assumes inclusion by bare name from core files
`ifndef LDB_DEFINES_VH
`define LDB_DEFINES_VH
`define LDB_IDX_ELEM_B1 8'hE0
`define LDB_IDX_ELEM_B2 8'hE2
`define LDB_IDX_FRAME_B1 8'hE4
`define LDB_IDX_FRAME_B2 8'hE6
`define LDB_IDX_CHAN_ASSIGN 8'hEA
`define LDB_IDX_DATA_PARAM 8'hEC
`define LDB_IDX_CONTROL 8'hEE
`define LDB_IDX_STATUS 8'hF0
`define LDB_IDX_SRC_FI_B2 8'hF2
`define LDB_IDX_BYTES_LO 8'hF8
`define LDB_IDX_BYTES_HI 8'hFA
`define LDB_KIND_MSB 3
`define LDB_KIND_RST 4'h0
`define LDB_KIND_TIEOFF 4'h0
`define LDB_KIND_LEGAL 4'h4
`define LDB_CTRL_START 0
`define LDB_CTRL_BUFSEL 1
`define LDB_CTRL_DBLIDX 2
`define LDB_CTRL_LEGACY 3
`define LDB_DP_SIZE_B1_LSB 0
`define LDB_DP_SIZE_B2_LSB 2
`define LDB_DP_RST 4'h0
`define LDB_DP_TIEOFF 4'h0
`define LDB_FIFO_DEPTH 8
`define LDB_FIFO_WIDTH 32
`endif

// ### core/ldb_fifo.v
// parameterised flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ldb_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ### core/ldb_sizing.v
// display dma sizing block: apb registers, block byte count, element sequencer, output fifo
// assumes apb master on ref_clk; source words arrive on src_*; display drains vid_*
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ldb_defines.vh"
module ldb_sizing (
  input wire ref_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire src_valid,
  input wire [31:0] src_data,
  output reg src_ready,
  output reg [31:0] src_addr,
  input wire vid_ready,
  output reg vid_valid,
  output reg [31:0] vid_data,
  output reg block_done
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [15:0] elem_reg [0:1];
  reg [15:0] frame_reg [0:1];
  reg [`LDB_KIND_MSB:0] kind_reg;
  reg [15:0] assign_hi_reg;
  reg [3:0] dparam_reg;
  reg [31:0] src_fi_b2_reg;
  reg [3:0] ctrl_reg;
  reg busy_reg;
  reg done_flag_reg;
  reg cur_buf_reg;
  reg [15:0] elem_cnt_reg;
  reg [15:0] frame_cnt_reg;
  wire legacy;
  wire [`LDB_KIND_MSB:0] kind_eff;
  wire [3:0] dparam_eff;
  wire [9:0] word_idx;
  wire acc;
  wire wr;
  reg hit;
  reg [31:0] rd_next;
  assign legacy = ctrl_reg[`LDB_CTRL_LEGACY];
  assign kind_eff = legacy ? `LDB_KIND_TIEOFF : kind_reg;
  assign dparam_eff = legacy ? `LDB_DP_TIEOFF : dparam_reg;
  assign word_idx = paddr[11:2];
  assign acc = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite; // write lands on the completing edge

  // ---------------------------------------------------------------
  // block byte count
  // ---------------------------------------------------------------
  function [2:0] size_bytes;
    input [1:0] code;
    begin
      case (code)
        2'h0: size_bytes = 3'h1;
        2'h1: size_bytes = 3'h2;
        2'h2: size_bytes = 3'h4;
        default: size_bytes = 3'h4;
      endcase
    end
  endfunction
  wire [1:0] dt_b1 = dparam_eff[`LDB_DP_SIZE_B1_LSB+1:`LDB_DP_SIZE_B1_LSB];
  wire [1:0] dt_b2 = dparam_eff[`LDB_DP_SIZE_B2_LSB+1:`LDB_DP_SIZE_B2_LSB];
  wire [31:0] prod_b1 = elem_reg[0] * frame_reg[0];
  wire [31:0] prod_b2 = elem_reg[1] * frame_reg[1];
  wire [34:0] bytes_b1 = prod_b1 * size_bytes(dt_b1);
  wire [34:0] bytes_b2 = prod_b2 * size_bytes(dt_b2);
  wire [34:0] bytes_sel = ctrl_reg[`LDB_CTRL_BUFSEL] ? bytes_b2 : bytes_b1;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  always @* begin
    hit = 1'b1;
    rd_next = 32'h0000_0000;
    if (word_idx == {2'h0, `LDB_IDX_ELEM_B1}) begin
      rd_next = {16'h0000, elem_reg[0]};
    end else if (word_idx == {2'h0, `LDB_IDX_ELEM_B2}) begin
      rd_next = {16'h0000, elem_reg[1]};
    end else if (word_idx == {2'h0, `LDB_IDX_FRAME_B1}) begin
      rd_next = {16'h0000, frame_reg[0]};
    end else if (word_idx == {2'h0, `LDB_IDX_FRAME_B2}) begin
      rd_next = {16'h0000, frame_reg[1]};
    end else if (word_idx == {2'h0, `LDB_IDX_CHAN_ASSIGN}) begin
      hit = ~legacy;
      rd_next = {16'h0000, assign_hi_reg[15:4], kind_eff};
    end else if (word_idx == {2'h0, `LDB_IDX_DATA_PARAM}) begin
      hit = ~legacy;
      rd_next = {28'h0000000, dparam_eff};
    end else if (word_idx == {2'h0, `LDB_IDX_CONTROL}) begin
      rd_next = {28'h0000000, ctrl_reg};
    end else if (word_idx == {2'h0, `LDB_IDX_STATUS}) begin
      rd_next = {29'h00000000, cur_buf_reg, done_flag_reg, busy_reg};
    end else if (word_idx == {2'h0, `LDB_IDX_SRC_FI_B2}) begin
      rd_next = src_fi_b2_reg;
    end else if (word_idx == {2'h0, `LDB_IDX_BYTES_LO}) begin
      rd_next = bytes_sel[31:0];
    end else if (word_idx == {2'h0, `LDB_IDX_BYTES_HI}) begin
      rd_next = {29'h00000000, bytes_sel[34:32]};
    end else begin
      hit = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~hit;
      prdata <= (acc & ~pwrite & hit) ? rd_next : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // buffer size registers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_buf
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          elem_reg[gi] <= 16'h0000;
          frame_reg[gi] <= 16'h0000;
        end else if (wr) begin
          if (word_idx == {2'h0, (gi == 0) ? `LDB_IDX_ELEM_B1 : `LDB_IDX_ELEM_B2}) begin
            elem_reg[gi] <= pwdata[15:0];
          end
          if (word_idx == {2'h0, (gi == 0) ? `LDB_IDX_FRAME_B1 : `LDB_IDX_FRAME_B2}) begin
            frame_reg[gi] <= pwdata[15:0];
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      kind_reg <= `LDB_KIND_RST;
      assign_hi_reg <= 16'h0000;
      dparam_reg <= `LDB_DP_RST;
      src_fi_b2_reg <= 32'h0000_0000;
      ctrl_reg <= 4'h0;
    end else begin
      if (wr && !legacy && word_idx == {2'h0, `LDB_IDX_CHAN_ASSIGN}) begin
        kind_reg <= pwdata[`LDB_KIND_MSB:0]; // software writes 0100
        assign_hi_reg <= pwdata[15:0];
      end
      if (wr && !legacy && word_idx == {2'h0, `LDB_IDX_DATA_PARAM}) begin
        dparam_reg <= pwdata[3:0];
      end
      if (wr && word_idx == {2'h0, `LDB_IDX_SRC_FI_B2}) begin
        src_fi_b2_reg <= pwdata;
      end
      if (wr && word_idx == {2'h0, `LDB_IDX_CONTROL}) begin
        ctrl_reg <= pwdata[3:0];
      end else if (!busy_reg) begin
        ctrl_reg[`LDB_CTRL_START] <= 1'b0; // clear once accepted, empty blocks too
      end
    end
  end

  // ---------------------------------------------------------------
  // element sequencer
  // ---------------------------------------------------------------
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire take = busy_reg & src_valid & src_ready;
  wire last_elem = (elem_cnt_reg == elem_reg[cur_buf_reg] - 16'h0001);
  wire last_frame = (frame_cnt_reg == frame_reg[cur_buf_reg] - 16'h0001);
  wire [2:0] cur_sz = size_bytes(cur_buf_reg ? dt_b2 : dt_b1);
  wire dbl_idx = ctrl_reg[`LDB_CTRL_DBLIDX];
  wire start_ok = ctrl_reg[`LDB_CTRL_START] & ~busy_reg;
  wire start_buf = ctrl_reg[`LDB_CTRL_BUFSEL];
  wire empty_blk = (elem_reg[start_buf] == 16'h0000) | (frame_reg[start_buf] == 16'h0000);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      cur_buf_reg <= 1'b0;
      elem_cnt_reg <= 16'h0000;
      frame_cnt_reg <= 16'h0000;
      src_addr <= 32'h0000_0000;
      src_ready <= 1'b0;
      block_done <= 1'b0;
    end else begin
      block_done <= 1'b0;
      if (start_ok) begin
        cur_buf_reg <= start_buf;
        elem_cnt_reg <= 16'h0000;
        frame_cnt_reg <= 16'h0000;
        src_addr <= 32'h0000_0000;
        done_flag_reg <= empty_blk;
        busy_reg <= ~empty_blk;
        block_done <= empty_blk;
        src_ready <= ~empty_blk & fifo_in_ready;
      end else if (busy_reg) begin
        src_ready <= fifo_in_ready & ~take; // no take right after a take: ready lags the fifo count
        if (take) begin
          if (last_elem) begin
            elem_cnt_reg <= 16'h0000;
            if (cur_buf_reg & dbl_idx) begin
              src_addr <= src_addr + {29'h00000000, cur_sz} + src_fi_b2_reg;
            end else begin
              src_addr <= src_addr + {29'h00000000, cur_sz};
            end
            if (last_frame) begin
              busy_reg <= 1'b0;
              done_flag_reg <= 1'b1;
              block_done <= 1'b1;
            end else begin
              frame_cnt_reg <= frame_cnt_reg + 16'h0001;
            end
          end else begin
            elem_cnt_reg <= elem_cnt_reg + 16'h0001;
            src_addr <= src_addr + {29'h00000000, cur_sz};
          end
        end
      end else begin
        src_ready <= 1'b0;
      end
    end
  end

  ldb_fifo #(
    .WIDTH(`LDB_FIFO_WIDTH),
    .DEPTH(`LDB_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(take),
    .in_ready(fifo_in_ready),
    .in_data(src_data),
    .out_valid(fifo_out_valid),
    .out_ready(~vid_valid | vid_ready),
    .out_data(fifo_out_data)
  );

  // registered output stage toward the display
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      vid_valid <= 1'b0;
      vid_data <= 32'h0000_0000;
    end else if (~vid_valid | vid_ready) begin
      vid_valid <= fifo_out_valid;
      vid_data <= fifo_out_data;
    end
  end
endmodule
`default_nettype wire

// ### sim/ldb_sizing_assertions.sv
// checker on the sizing block's apb and video ports
// assumes binding into ldb_sizing, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module ldb_sizing_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic vid_ready,
  input wire logic vid_valid,
  input wire logic [31:0] vid_data,
  input wire logic block_done
);
  logic leg_reg;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      leg_reg <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == 12'h3B8) begin
      leg_reg <= pwdata[3];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // apb steps
  // ----
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_rd(a);
    s_take ##0 (!pwrite && paddr == a) ##1 pready;
  endsequence
  property p_ans; s_take |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("apb answer late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("prdata outside answer");
  property p_hide;
    s_take ##0 (leg_reg && (paddr == 12'h3A8 || paddr == 12'h3B0)) |=> pslverr && prdata == 32'h0;
  endproperty
  a_hide: assert property (p_hide) else $error("legacy word not hidden");
  property p_e1; s_rd(12'h380) |-> prdata[31:16] == 16'h0; endproperty
  a_e1: assert property (p_e1) else $error("element count too wide");
  property p_f1; s_rd(12'h390) |-> prdata[31:16] == 16'h0; endproperty
  a_f1: assert property (p_f1) else $error("frame count too wide");
  property p_kw; s_rd(12'h3A8) |-> prdata[31:16] == 16'h0; endproperty
  a_kw: assert property (p_kw) else $error("assignment word too wide");
  property p_done; block_done |=> !block_done; endproperty
  a_done: assert property (p_done) else $error("block_done too long");
  property p_vhold; vid_valid && !vid_ready |=> vid_valid && $stable(vid_data); endproperty
  a_vhold: assert property (p_vhold) else $error("video word dropped");
endmodule
bind ldb_sizing ldb_sizing_chk u_chk (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .vid_ready, .vid_valid, .vid_data, .block_done);
`default_nettype wire

// ### sim/ldb_display_model.sv
// display side: takes video words, stalls at random or on hold
// assumes one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module ldb_display_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hold,
  output logic vid_ready
);
  always @(posedge ref_clk) begin
    if (sys_rst || hold) begin
      vid_ready <= 1'b0;
    end else begin
      vid_ready <= $urandom_range(0, 2) != 0;
    end
  end
endmodule
`default_nettype wire

// ### sim/ldb_sizing_tb_top.sv
// self-checking bench for the sizing block
// assumes the design and display model in the same run
`timescale 1ns/10ps
`default_nettype none
module ldb_sizing_tb_top;
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, src_valid = 0, hold = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, src_data = 0, prdata, src_addr, vid_data;
  logic pready, pslverr, src_ready, vid_ready, vid_valid, block_done;
  logic [32:0] eq[$];
  logic [31:0] vq[$];
  int mismatches = 0, compares = 0, dones = 0;
  always #10 ref_clk = ~ref_clk;
  ldb_sizing dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .src_valid, .src_data, .src_ready, .src_addr, .vid_ready, .vid_valid, .vid_data, .block_done);
  ldb_display_model u_disp (.ref_clk, .sys_rst, .hold, .vid_ready);
  // ----
  // checking
  // ----
  task automatic chk(string nm, logic [32:0] s, logic [32:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (block_done === 1'b1) dones++;
    if (pready === 1'b1) chk("apb", {pslverr, prdata}, eq.size() ? eq.pop_front() : 33'h1FFFFFFFF);
    if (vid_valid === 1'b1 && vid_ready === 1'b1) chk("vid", vid_data, vq.size() ? vq.pop_front() : ~vid_data);
  end
  // ----
  // drivers
  // ----
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
    int n;
    n = 0;
    eq.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic blk(logic b, logic [15:0] ne, logic [15:0] nf, logic [1:0] sz, logic x, logic [31:0] fi);
    int nb, d0, n;
    logic [31:0] v;
    nb = sz[1] ? 4 : sz + 1;
    d0 = dones;
    apb(1, b ? 12'h388 : 12'h380, {16'h0, ne}, 0);
    apb(1, b ? 12'h398 : 12'h390, {16'h0, nf}, 0);
    apb(1, 12'h3B0, {28'h0, sz, sz}, 0);
    apb(1, 12'h3C8, fi, 0);
    apb(0, 12'h3C8, 0, fi);
    apb(1, 12'h3B8, {29'h0, x, b, 1'b0}, 0);
    apb(0, 12'h3E0, 0, ne * nf * nb);
    apb(0, 12'h3E8, 0, 0);
    apb(1, 12'h3B8, {29'h0, x, b, 1'b1}, 0);
    for (int i = 0; i < ne * nf; i++) begin
      n = 0;
      v = $urandom;
      src_valid <= 1;
      src_data <= v;
      do @(posedge ref_clk); while (src_ready !== 1'b1 && ++n < 200);
      vq.push_back(v);
    end
    src_valid <= 0;
    for (n = 0; n < 50 && dones == d0; n++) @(posedge ref_clk);
    chk("done", dones - d0, 1);
    chk("addr", src_addr, 32'(ne * nf * nb + ((x & b) ? nf * fi : 0)));
    apb(0, 12'h3C0, 0, {b, 2'b10});
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    logic [31:0] r;
    r = $urandom(67700);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    apb(0, 12'h3A8, 0, 0);
    apb(0, 12'h3FC, 0, 33'h100000000);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      apb(1, 12'(12'h380 + 8 * i), 32'hFFFF, 0);
      apb(0, 12'(12'h380 + 8 * i), 0, 33'hFFFF);
      apb(1, 12'(12'h380 + 8 * i), r, 0);
      apb(0, 12'(12'h380 + 8 * i), 0, r[15:0]);
    end
    apb(1, 12'h3A8, r, 0);
    apb(0, 12'h3A8, 0, r[15:0]);
    apb(1, 12'h3A8, 32'h4, 0);
    apb(1, 12'h3B8, 32'h8, 0);
    apb(0, 12'h3A8, 0, 33'h100000000);
    apb(0, 12'h3B0, 0, 33'h100000000);
    apb(1, 12'h3A8, 0, 33'h100000000);
    apb(1, 12'h3B8, 32'h0, 0);
    apb(0, 12'h3A8, 0, 32'h4);
    for (int s = 0; s < 4; s++) blk(s[0], 3, 2, 2'(s), s[1], 32'hFFFF_FFF0);
    blk(1, 0, 5, 1, 0, 0);
    fork
      begin
        hold <= 1;
        repeat (80) @(posedge ref_clk);
        chk("full", src_ready, 0);
        hold <= 0;
      end
    join_none
    blk(0, 8, 2, 2, 0, 0);
    for (int n = 0; n < 300 && vq.size() > 0; n++) @(posedge ref_clk);
    chk("drain", vq.size(), 0);
    final_report;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
